//--- inc/ecl_pkg.sv
// constants for the encoder counter and latch control channel
// assumes a single clock domain and a synchronous active-high reset
package ecl_pkg;

   // ==========================================
   // command byte field positions
   localparam int CMD_REG_COMM_BIT = 7;
   localparam int CMD_CLEAR_ON_LATCH_BIT = 5;
   localparam int CMD_ARM_FALL_BIT = 4;
   localparam int CMD_ARM_RISE_BIT = 3;
   localparam int CMD_PRESET_BIT = 2;
   localparam int CMD_SHOW_CAPT_BIT = 1;
   localparam int CMD_ARM_INDEX_BIT = 0;

   // ==========================================
   // state byte field positions
   localparam int STS_REG_COMM_BIT = 7;
   localparam int STS_GATE_LEVEL_BIT = 4;
   localparam int STS_INDEX_LEVEL_BIT = 3;
   localparam int STS_PRESET_ACK_BIT = 2;
   localparam int STS_SHOW_CAPT_BIT = 1;
   localparam int STS_INDEX_VALID_BIT = 0;

   // ==========================================
   // widths and values after reset
   localparam int ECL_DATA_W = 32;
   localparam logic [7:0] ECL_STATE_RESET = 8'h00;
   localparam logic [31:0] ECL_WORD_RESET = 32'h0000_0000;
   localparam int ECL_SYNC_STAGES = 2;

endpackage

//--- hdl/ecl_sync2.sv
// two flip-flop synchroniser for a group of asynchronous pins
// assumes the pins are slow compared with clk
module ecl_sync2 #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // pins and synchronised levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule

//--- hdl/ecl_counter_latch.sv
// encoder counter channel: quadrature count, preset, latch capture, state byte
// assumes the coupler image (command byte, preset word) is on clk; pins are async
module ecl_counter_latch
   import ecl_pkg::*;
#(
   parameter bit HAS_LATCH_INPUTS = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // coupler output image
   input wire logic [7:0] counter_command_byte,
   input wire logic [ECL_DATA_W-1:0] preset_value_word,
   // coupler input image
   output logic [7:0] counter_state_byte,
   output logic [ECL_DATA_W-1:0] input_value_word,
   // encoder pins
   input wire logic enc_a,
   input wire logic enc_b,
   input wire logic latch_pin,
   input wire logic index_pin,
   // gate lock configuration
   input wire logic lock_on_gate_high,
   input wire logic lock_on_gate_low
);

   // ==========================================
   // pin synchronisation
   logic [3:0] pins_sync;
   logic a_s, b_s, gate_s, index_s;

   ecl_sync2 #(.WIDTH(4)) u_sync (
      .clk(clk),
      .srst(srst),
      .async_in({enc_a, enc_b, latch_pin, index_pin}),
      .sync_out(pins_sync)
   );

   assign a_s = pins_sync[3];
   assign b_s = pins_sync[2];
   // the two-channel variant has no latch or index pins
   assign gate_s = HAS_LATCH_INPUTS ? pins_sync[1] : 1'b0;
   assign index_s = HAS_LATCH_INPUTS ? pins_sync[0] : 1'b0;

   // ==========================================
   // command decode
   logic proc_mode;
   logic cmd_clear, cmd_fall, cmd_rise, cmd_preset, cmd_show, cmd_index;

   assign proc_mode = ~counter_command_byte[CMD_REG_COMM_BIT];
   assign cmd_clear = proc_mode & HAS_LATCH_INPUTS & counter_command_byte[CMD_CLEAR_ON_LATCH_BIT];
   assign cmd_fall = proc_mode & HAS_LATCH_INPUTS & counter_command_byte[CMD_ARM_FALL_BIT];
   assign cmd_rise = proc_mode & HAS_LATCH_INPUTS & counter_command_byte[CMD_ARM_RISE_BIT];
   assign cmd_preset = proc_mode & counter_command_byte[CMD_PRESET_BIT];
   assign cmd_show = proc_mode & counter_command_byte[CMD_SHOW_CAPT_BIT];
   assign cmd_index = proc_mode & HAS_LATCH_INPUTS & counter_command_byte[CMD_ARM_INDEX_BIT];

   // ==========================================
   // state registers
   logic [ECL_DATA_W-1:0] count_ff, nxt_count;
   logic [ECL_DATA_W-1:0] capt_ff, nxt_capt;
   logic [ECL_DATA_W-1:0] value_ff, nxt_value;
   logic [7:0] state_ff, nxt_state;
   logic a_d_ff, b_d_ff, gate_d_ff, index_d_ff;
   logic fall_en_d_ff, rise_en_d_ff, index_en_d_ff, preset_d_ff;
   logic arm_fall_ff, nxt_arm_fall;
   logic arm_rise_ff, nxt_arm_rise;
   logic arm_index_ff, nxt_arm_index;
   logic index_valid_ff, nxt_index_valid;
   logic preset_ack_ff, nxt_preset_ack;

   // ==========================================
   // edge and arm helpers
   function automatic logic rose_now(input logic now_lvl, input logic prev_lvl);
      return now_lvl & ~prev_lvl;
   endfunction

   // one-shot arm: set on a 0->1 of the enable, held until its own capture, dropped with the enable;
   // a level-sensitive arm would recapture on every later pulse
   function automatic logic next_arm(input logic en, input logic en_d, input logic armed, input logic hit);
      return en & (~en_d | (armed & ~hit));
   endfunction

   // ==========================================
   // next-state logic
   logic step_up, step_dn, gate_rise, gate_fall, index_rise;
   logic capt_fall, capt_rise, capt_index, capture, locked;

   always_comb begin
      // x4 quadrature decode from the previous and present A/B levels
      step_up = (a_s ^ a_d_ff) & (a_s ^ b_s) | (b_s ^ b_d_ff) & ~(a_s ^ b_s);
      step_dn = (a_s ^ a_d_ff) & ~(a_s ^ b_s) | (b_s ^ b_d_ff) & (a_s ^ b_s);
      gate_rise = rose_now(gate_s, gate_d_ff);
      gate_fall = rose_now(~gate_s, ~gate_d_ff);
      index_rise = rose_now(index_s, index_d_ff);

      // a capture also needs its enable still high: an enable drop and a pin edge in one cycle
      // must not set the index valid flag once the controller has begun a re-arm
      capt_rise = arm_rise_ff & cmd_rise & gate_rise;
      capt_fall = arm_fall_ff & cmd_fall & gate_fall & ~cmd_rise;
      capt_index = arm_index_ff & cmd_index & index_rise;
      capture = capt_rise | capt_fall | capt_index;

      nxt_arm_rise = next_arm(cmd_rise, rise_en_d_ff, arm_rise_ff, capt_rise);
      nxt_arm_fall = next_arm(cmd_fall, fall_en_d_ff, arm_fall_ff, capt_fall);
      nxt_arm_index = next_arm(cmd_index, index_en_d_ff, arm_index_ff, capt_index);

      // valid clears only once the enable is low, so capture and clear never meet
      nxt_index_valid = capt_index | (index_valid_ff & cmd_index);

      nxt_capt = capture ? count_ff : capt_ff;

      locked = (lock_on_gate_high & gate_s) | (lock_on_gate_low & ~gate_s);
      nxt_count = count_ff;
      if (cmd_preset && !preset_d_ff) begin
         nxt_count = preset_value_word;
      end else if (capture && cmd_clear) begin
         nxt_count = ECL_WORD_RESET;
      end else if (!locked && step_up && !step_dn) begin
         nxt_count = count_ff + 32'h0000_0001;
      end else if (!locked && step_dn && !step_up) begin
         nxt_count = count_ff - 32'h0000_0001;
      end

      // ack rises once the preset load has happened and follows the bit down
      nxt_preset_ack = cmd_preset & (preset_d_ff | preset_ack_ff);

      nxt_value = cmd_show ? capt_ff : count_ff;

      nxt_state = ECL_STATE_RESET;
      nxt_state[STS_REG_COMM_BIT] = ~proc_mode;
      if (proc_mode) begin
         nxt_state[STS_GATE_LEVEL_BIT] = gate_s;
         nxt_state[STS_INDEX_LEVEL_BIT] = index_s;
         nxt_state[STS_PRESET_ACK_BIT] = preset_ack_ff;
         nxt_state[STS_SHOW_CAPT_BIT] = cmd_show;
         nxt_state[STS_INDEX_VALID_BIT] = index_valid_ff;
      end
   end

   // ==========================================
   // pin and enable history
   // history resets to the idle pin level, so the release of reset shows no false edge
   always_ff @(posedge clk) begin
      if (srst) begin
         a_d_ff <= 1'b0;
         b_d_ff <= 1'b0;
         gate_d_ff <= 1'b0;
         index_d_ff <= 1'b0;
         fall_en_d_ff <= 1'b0;
         rise_en_d_ff <= 1'b0;
         index_en_d_ff <= 1'b0;
         preset_d_ff <= 1'b0;
      end else begin
         a_d_ff <= a_s;
         b_d_ff <= b_s;
         gate_d_ff <= gate_s;
         index_d_ff <= index_s;
         fall_en_d_ff <= cmd_fall;
         rise_en_d_ff <= cmd_rise;
         index_en_d_ff <= cmd_index;
         preset_d_ff <= cmd_preset;
      end
   end

   // ==========================================
   // counter, capture and arm registers
   always_ff @(posedge clk) begin
      if (srst) begin
         count_ff <= ECL_WORD_RESET;
         capt_ff <= ECL_WORD_RESET;
         arm_fall_ff <= 1'b0;
         arm_rise_ff <= 1'b0;
         arm_index_ff <= 1'b0;
         index_valid_ff <= 1'b0;
         preset_ack_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         capt_ff <= nxt_capt;
         arm_fall_ff <= nxt_arm_fall;
         arm_rise_ff <= nxt_arm_rise;
         arm_index_ff <= nxt_arm_index;
         index_valid_ff <= nxt_index_valid;
         preset_ack_ff <= nxt_preset_ack;
      end
   end

   // ==========================================
   // coupler input image registers
   always_ff @(posedge clk) begin
      if (srst) begin
         value_ff <= ECL_WORD_RESET;
         state_ff <= ECL_STATE_RESET;
      end else begin
         value_ff <= nxt_value;
         state_ff <= nxt_state;
      end
   end

   assign counter_state_byte = state_ff;
   assign input_value_word = value_ff;

endmodule

//--- testbench/ecl_coupler_model.sv
// coupler model: hands the controller's command byte and preset word to the channel
// assumes the bench posts its requests on clk
module ecl_coupler_model (
   // clock
   input wire logic clk,
   // controller requests
   input wire logic [7:0] req_cmd,
   input wire logic [31:0] req_word,
   // output image
   output logic [7:0] cmd = 8'h00,
   output logic [31:0] word = 32'h0,
   // output image of a two-channel variant
   output logic [7:0] cmd_two = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====================
   // index enable masks the edge enables so a capture has one known source
   always @(posedge clk) begin
      cmd <= req_cmd[0] ? (req_cmd & 8'he7) : req_cmd;
      word <= req_word;
      // the variant has no latch or index pins, so its latch bits stay zero
      cmd_two <= req_cmd & 8'hc6;
   end
endmodule

//--- testbench/ecl_cl_checker.sv
// checker for the channel's state byte and shown value
// assumes binding to the channel top; all ports on clk
module ecl_cl_checker #(
   parameter bit HAS_LATCH_INPUTS = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // image and pins
   input wire logic [7:0] counter_command_byte,
   input wire logic [31:0] preset_value_word,
   input wire logic [7:0] counter_state_byte,
   input wire logic [31:0] input_value_word,
   input wire logic latch_pin,
   input wire logic index_pin
);
   logic [7:0] cb, sb;
   assign cb = counter_command_byte;
   assign sb = counter_state_byte;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ====================
   // preset: rise of the preset bit, then held two more cycles with live value shown
   sequence s_pre;
      $rose(cb[2]) && !cb[7] && !cb[1] ##1 (cb[2] && !cb[1]) [*2];
   endsequence
   chk_preset_load: assert property (s_pre |-> input_value_word == $past(preset_value_word, 2)) else $error("load");
   chk_preset_ack: assert property (s_pre |-> ##1 sb[2]) else $error("ack");
   chk_mode_ack: assert property (!cb[7] [*2] |-> !sb[7]) else $error("mode");
   chk_regcomm_quiet: assert property (cb[7] [*2] |-> sb == 8'h80) else $error("quiet");
   chk_show_echo: assert property ((!cb[7] && $stable(cb[1])) [*2] |-> sb[1] == cb[1]) else $error("echo");
   chk_gate_level: assert property ((!cb[7] && $stable(latch_pin)) [*5]
      |-> sb[4] == (HAS_LATCH_INPUTS & latch_pin)) else $error("gate");
   chk_index_level: assert property ((!cb[7] && $stable(index_pin)) [*5]
      |-> sb[3] == (HAS_LATCH_INPUTS & index_pin)) else $error("index level");
   chk_valid_clear: assert property (!cb[0] [*3] |-> !sb[0]) else $error("clear");
   chk_valid_arm: assert property ($rose(sb[0]) |-> $past(cb[0], 2) && $past(cb[0], 3)) else $error("arm");
endmodule
bind ecl_counter_latch ecl_cl_checker #(.HAS_LATCH_INPUTS(HAS_LATCH_INPUTS)) u_chk (.clk(clk), .srst(srst),
   .counter_command_byte(counter_command_byte), .preset_value_word(preset_value_word),
   .counter_state_byte(counter_state_byte), .input_value_word(input_value_word), .latch_pin(latch_pin),
   .index_pin(index_pin));

//--- testbench/testbench.sv
// bench: coupler model, pin stimulus and a reference counter compared at each result
// assumes the channel settles within eight clocks of any stimulus
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; $display("unexpected %0t: %h", $time, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, srst = 1, a = 0, b = 0, lp = 0, ip = 0, lh = 0, ll = 0;
   logic [7:0] rc = 0, cmd, st, cmd2, st2;
   logic [31:0] rw = 0, w = 0, word, val, val2, ec = 0, el = 0;
   int failures, compares;
   ecl_coupler_model cpl (.clk(clk), .req_cmd(rc), .req_word(rw), .cmd(cmd), .word(word), .cmd_two(cmd2));
   ecl_counter_latch dut (.clk(clk), .srst(srst), .counter_command_byte(cmd), .preset_value_word(word),
      .counter_state_byte(st), .input_value_word(val), .enc_a(a), .enc_b(b), .latch_pin(lp),
      .index_pin(ip), .lock_on_gate_high(lh), .lock_on_gate_low(ll));
   // two-channel variant: same pins, its latch and index bits must read zero
   ecl_counter_latch #(.HAS_LATCH_INPUTS(1'b0)) dut_two (.clk(clk), .srst(srst), .counter_command_byte(cmd2),
      .preset_value_word(word), .counter_state_byte(st2), .input_value_word(val2), .enc_a(a), .enc_b(b),
      .latch_pin(lp), .index_pin(ip), .lock_on_gate_high(lh), .lock_on_gate_low(ll));
   // ====================
   // helpers end at a falling edge, where outputs have settled
   task automatic settle;
      repeat (8) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic put(input logic [7:0] c);
      @(posedge clk) begin
         rc <= c;
         rw <= w;
      end
      settle();
   endtask
   task automatic pin(input logic [1:0] v);
      @(posedge clk) {ip, lp} <= v;
      settle();
   endtask
   // a leads b, so each step counts up by one
   task automatic enc(input int n);
      repeat (n) begin
         @(posedge clk) {a, b} <= {~b, a};
         repeat (3) @(posedge clk);
      end
      ec += n;
      settle();
   endtask
   task automatic conclude;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial forever #2 clk = ~clk;
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      conclude();
   end
   initial begin
      void'($urandom(32'h8a93813a));
      repeat (12) @(posedge clk);
      srst <= 0;
      @(negedge clk);
      `CHK(st, 8'h00)
      w = $urandom();
      put(8'h04);
      ec = w;
      `CHK(val, ec)
      `CHK(st, 8'h04)
      put(8'h00);
      enc(9);
      `CHK(val, ec)
      $display("test preset done");
      put(8'h03);
      pin(2'b10);
      el = ec;
      `CHK(st, 8'h0b)
      `CHK(val, el)
      pin(2'b00);
      enc(4);
      pin(2'b10);
      `CHK(val, el)
      pin(2'b00);
      put(8'h02);
      for (int i = 0; i < 20 && st[0] !== 1'b0; i++) @(negedge clk);
      `CHK(st[0], 1'b0)
      put(8'h03);
      pin(2'b10);
      el = ec;
      `CHK(val, el)
      $display("test index done");
      put(8'h2a);
      pin(2'b01);
      el = ec;
      ec = 0;
      `CHK(st, 8'h12)
      `CHK(val, el)
      `CHK(st2, 8'h02)
      `CHK(val2, 32'h0)
      put(8'h20);
      `CHK(val, ec)
      put(8'h1a);
      enc(2);
      pin(2'b00);
      `CHK(val, el)
      enc(2);
      pin(2'b01);
      el = ec;
      `CHK(val, el)
      put(8'h02);
      put(8'h12);
      enc(3);
      pin(2'b00);
      el = ec;
      `CHK(val, el)
      $display("test edges done");
      put(8'h00);
      @(posedge clk) lh <= 1;
      pin(2'b01);
      enc(2);
      ec -= 2;
      `CHK(val, ec)
      @(posedge clk) begin
         lh <= 0;
         ll <= 1;
      end
      pin(2'b00);
      enc(2);
      ec -= 2;
      `CHK(val, ec)
      put(8'h80);
      `CHK(st, 8'h80)
      $display("test lock and mode done");
      conclude();
   end
endmodule
